// ==== hdl/security_fault_monitor_consts.svh ====
// offsets, field positions, reset values and counts of the fault monitor
`ifndef SECURITY_FAULT_MONITOR_CONSTS_SVH
`define SECURITY_FAULT_MONITOR_CONSTS_SVH
// register offsets
`define SFM_REG_RESET_CAUSE  4'h0
`define SFM_REG_EXC_STATUS   4'h1
`define SFM_REG_EXC_MASK     4'h2
`define SFM_REG_LIGHT_SEL    4'h3
`define SFM_REG_HV_STATUS    4'h4
`define SFM_REG_SP_LIMIT_USR 4'h5
`define SFM_REG_SP_LIMIT_SYS 4'h6
`define SFM_REG_SP_LIMIT_SSM 4'h7
`define SFM_REG_CONFIG       4'h8
`define SFM_REG_MODE         4'h9
// reset cause bits
`define SFM_RC_VOLTAGE   0
`define SFM_RC_FREQ      1
`define SFM_RC_TEMP      2
`define SFM_RC_LIGHT     3
`define SFM_RC_PARITY    4
`define SFM_RC_EXTERNAL  5
`define SFM_RC_W         6
// exception reason bits
`define SFM_EX_NVM_LIGHT 0
`define SFM_EX_FI_PC     1
`define SFM_EX_FI_SP     2
`define SFM_EX_FI_PROGRAM_STATUS_WORD_HIGH   3
`define SFM_EX_FI_DES    4
`define SFM_EX_FI_ARITH  5
`define SFM_EX_ECC       6
`define SFM_EX_SP_LIMIT  7
`define SFM_EX_W         8
// light detect selection codes
`define SFM_LSEL_OFF     2'h0
`define SFM_LSEL_FUNC_A  2'h1
`define SFM_LSEL_FUNC_B  2'h2
// config bits
`define SFM_CFG_INV_ECC  0
// reset values
`define SFM_EXC_MASK_RST 8'hff
`define SFM_LSEL_RST     2'h1
`define SFM_RST_CNT      4'h3
`endif

// ==== hdl/security_fault_monitor_pkg.sv ====
// types of the fault monitor
package security_fault_monitor_pkg;
  typedef enum logic [1:0] {
    MODE_USER,
    MODE_SYSTEM,
    MODE_SUPER
  } cpu_mode_t;
  typedef enum logic [1:0] {
    SUB_BOOT,
    SUB_TEST,
    SUB_CONTACTLESS
  } super_mode_t;
  typedef enum logic [1:0] {
    ST_RESET,
    ST_RUN,
    ST_CHIP_RESET
  } mon_state_t;
endpackage

// ==== hdl/security_fault_monitor.sv ====
// fault and tamper monitor: sensor resets, fault exceptions, cause registers
//
// Summary of operation
// - voltage, frequency, temperature or light out of range forces a chip reset.
// - a forced reset aborts the program; an exception interrupts program flow.
// - memory light detector and fault-injection detectors raise exceptions, not resets.
// - fault detection covers PC, SP, status word high, DES and arithmetic units.
// - on a system reset all state except the cause bits and input synchronisers returns to reset; a chip reset spares the cause, sp limits and test lock.
// - the cause of the last reset is recorded and readable.
// - each raised exception leaves a readable reason indication.
// - sensors are on automatically in every mode except factory test.
// - software cannot switch the sensors off.
// - the sensor to reset or exception mapping is fixed in hardware.
// - test mode is disabled permanently once the fuse is blown.
// - stack pointer and limit check exist for user, system and super modes.
// - the active stack pointer reaching its limit raises an exception.
// - high voltage check runs per write, readable only, raises nothing.
// - software picks one of two memory light detectors or disables both.
// - with inverse error correction on, detected errors raise an exception.
// - the memory corrects single-bit errors per byte without software.
// - a program memory parity error forces a chip reset.
`timescale 1ns/1ps
`include "security_fault_monitor_consts.svh"
module security_fault_monitor
  import security_fault_monitor_pkg::*;
#(
  parameter int SP_W = 16                      // stack pointer width
) (
  input  wire logic            i_mclk,           // system clock
  input  wire logic            i_reset_n,        // synchronous reset, active low
  input  wire logic            i_ext_reset_n,    // external reset pin, active low
  input  wire logic            i_sens_voltage,   // voltage out of range
  input  wire logic            i_sens_freq,      // frequency out of range
  input  wire logic            i_sens_temp,      // temperature out of range
  input  wire logic            i_sens_light,     // surface light sensor
  input  wire logic            i_nvm_light_a,    // memory light detect, function a
  input  wire logic            i_nvm_light_b,    // memory light detect, function b
  input  wire logic            i_fi_pc,          // fault on program counter
  input  wire logic            i_fi_sp,          // fault on stack pointer
  input  wire logic            i_fi_program_status_word_high,        // fault on program_status_word_high
  input  wire logic            i_fi_des,         // fault on des coprocessor
  input  wire logic            i_fi_arith,       // fault on arithmetic coprocessor
  input  wire logic            i_ecc_err,        // inverse ecc error detected
  input  wire logic            i_ecc_corr,       // single-bit error corrected
  input  wire logic            i_rom_parity_err, // program memory parity error
  input  wire logic            i_nvm_write,      // nvm write sequence pulse
  input  wire logic            i_hv_ok,          // high voltage sensor result
  input  wire logic            i_test_fuse,      // test mode fuse blown
  input  wire logic [1:0]      i_cpu_mode,       // cpu mode
  input  wire logic [1:0]      i_super_mode,     // super mode sub-mode
  input  wire logic [SP_W-1:0] i_sp,             // active stack pointer
  input  wire logic [3:0]      i_addr,           // register address
  input  wire logic [15:0]     i_wdata,          // register write data
  input  wire logic            i_wr,             // write strobe
  input  wire logic            i_rd,             // read strobe
  output logic [15:0]          o_rdata,          // read data, one cycle later
  output logic                 o_chip_reset,     // forced chip reset request
  output logic                 o_exception,      // exception request to cpu
  output logic                 o_irq,            // level interrupt
  output logic                 o_sensors_on,     // sensors enabled
  output logic                 o_test_avail      // test mode available
);

  if (SP_W < 1 || SP_W > 16) begin : g_bad_sp_w
    $error("SP_W must be 1..16");
  end

  // ==========================================================
  // input synchronisers
  // ==========================================================
  localparam int NS = 19;
  wire  [NS-1:0] raw_in = {i_ext_reset_n, i_sens_voltage, i_sens_freq, i_sens_temp,
                           i_sens_light, i_nvm_light_a, i_nvm_light_b, i_fi_pc, i_fi_sp,
                           i_fi_program_status_word_high, i_fi_des, i_fi_arith, i_ecc_err, i_ecc_corr,
                           i_rom_parity_err, i_nvm_write, i_hv_ok, i_test_fuse, 1'b0};
  logic [NS-1:0] sync1_q;
  logic [NS-1:0] sync2_q;
  always_ff @(posedge i_mclk) begin
    sync1_q <= raw_in;
    sync2_q <= sync1_q;
  end
  wire ext_rst_n = sync2_q[18];
  wire s_volt    = sync2_q[17];
  wire s_freq    = sync2_q[16];
  wire s_temp    = sync2_q[15];
  wire s_light   = sync2_q[14];
  wire nvm_la    = sync2_q[13];
  wire nvm_lb    = sync2_q[12];
  wire fi_pc     = sync2_q[11];
  wire fi_sp     = sync2_q[10];
  wire fi_program_status_word_high   = sync2_q[9];
  wire fi_des    = sync2_q[8];
  wire fi_arith  = sync2_q[7];
  wire ecc_err   = sync2_q[6];
  wire ecc_corr  = sync2_q[5];
  wire parity    = sync2_q[4];
  wire nvm_wr    = sync2_q[3];
  wire hv_ok     = sync2_q[2];
  wire fuse      = sync2_q[1];

  // ==========================================================
  // register decode
  // ==========================================================
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    return a == off;
  endfunction

  wire wr_cause = i_wr && hit(i_addr, `SFM_REG_RESET_CAUSE);
  wire wr_exc   = i_wr && hit(i_addr, `SFM_REG_EXC_STATUS);
  wire wr_mask  = i_wr && hit(i_addr, `SFM_REG_EXC_MASK);
  wire wr_lsel  = i_wr && hit(i_addr, `SFM_REG_LIGHT_SEL);
  wire wr_cfg   = i_wr && hit(i_addr, `SFM_REG_CONFIG);
  wire [2:0] wr_lim;
  assign wr_lim[0] = i_wr && hit(i_addr, `SFM_REG_SP_LIMIT_USR);
  assign wr_lim[1] = i_wr && hit(i_addr, `SFM_REG_SP_LIMIT_SYS);
  assign wr_lim[2] = i_wr && hit(i_addr, `SFM_REG_SP_LIMIT_SSM);

  // ==========================================================
  // test mode lock and sensor enable
  // ==========================================================
  logic test_locked_q;
  // once the fuse reads blown, the lock holds until a system reset (i_reset_n low)
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      test_locked_q <= 1'b0;
    end else if (fuse) begin
      test_locked_q <= 1'b1;
    end
  end
  wire test_avail = !test_locked_q && !fuse;
  wire in_test    = (i_cpu_mode == 2'(MODE_SUPER)) && (i_super_mode == 2'(SUB_TEST))
                    && test_avail;
  // no register bit feeds this; software has no way to drop it
  wire sensors_on = !in_test;

  // ==========================================================
  // fixed response mapping
  // ==========================================================
  wire [`SFM_RC_W-1:0] rst_ev;
  assign rst_ev[`SFM_RC_VOLTAGE]  = sensors_on && s_volt;
  assign rst_ev[`SFM_RC_FREQ]     = sensors_on && s_freq;
  assign rst_ev[`SFM_RC_TEMP]     = sensors_on && s_temp;
  assign rst_ev[`SFM_RC_LIGHT]    = sensors_on && s_light;
  assign rst_ev[`SFM_RC_PARITY]   = parity;
  assign rst_ev[`SFM_RC_EXTERNAL] = !ext_rst_n;
  wire force_reset = |rst_ev[`SFM_RC_PARITY:`SFM_RC_VOLTAGE];

  logic [1:0] lsel_q;
  logic       inv_ecc_q;
  wire nvm_light = (lsel_q == `SFM_LSEL_FUNC_A && nvm_la)
                   || (lsel_q == `SFM_LSEL_FUNC_B && nvm_lb);

  // ==========================================================
  // stack pointer limits, one per mode group
  // ==========================================================
  logic [SP_W-1:0] lim_q [3];
  wire  [2:0]      sp_at_lim;
  wire  [1:0]      mode_idx = (i_cpu_mode > 2'(MODE_SUPER)) ? 2'(MODE_SUPER) : i_cpu_mode;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sp
      always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
          lim_q[g] <= '0;
        end else if (wr_lim[g]) begin
          lim_q[g] <= i_wdata[SP_W-1:0];
        end
      end
      // limit zero means unconfigured
      assign sp_at_lim[g] = (mode_idx == 2'(g)) && (lim_q[g] != '0)
                            && (i_sp >= lim_q[g]);
    end
  endgenerate

  wire [`SFM_EX_W-1:0] exc_ev;
  assign exc_ev[`SFM_EX_NVM_LIGHT] = nvm_light;
  assign exc_ev[`SFM_EX_FI_PC]     = fi_pc;
  assign exc_ev[`SFM_EX_FI_SP]     = fi_sp;
  assign exc_ev[`SFM_EX_FI_PROGRAM_STATUS_WORD_HIGH]   = fi_program_status_word_high;
  assign exc_ev[`SFM_EX_FI_DES]    = fi_des;
  assign exc_ev[`SFM_EX_FI_ARITH]  = fi_arith;
  assign exc_ev[`SFM_EX_ECC]       = inv_ecc_q && ecc_err;
  assign exc_ev[`SFM_EX_SP_LIMIT]  = |sp_at_lim;

  // ==========================================================
  // state machine: hold a forced reset for a few cycles
  // ==========================================================
  mon_state_t state_q;
  mon_state_t state_d;
  logic [3:0] rst_cnt_q;
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        state_d = ST_RUN;
      end
      ST_RUN: begin
        if (force_reset) state_d = ST_CHIP_RESET;
      end
      ST_CHIP_RESET: begin
        if (rst_cnt_q == 4'h0) state_d = ST_RESET;
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
  end
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      state_q   <= ST_RESET;
      rst_cnt_q <= `SFM_RST_CNT;
    end else begin
      state_q   <= state_d;
      rst_cnt_q <= (state_q == ST_CHIP_RESET) ? rst_cnt_q - 4'h1 : `SFM_RST_CNT;
    end
  end

  // ==========================================================
  // cause and reason registers
  // ==========================================================
  logic [`SFM_RC_W-1:0] cause_q;
  logic [`SFM_EX_W-1:0] exc_q;
  logic [`SFM_EX_W-1:0] mask_q;
  logic                 hv_fail_q;
  logic                 hv_done_q;
  logic [7:0]           corr_cnt_q;
  wire  [`SFM_RC_W-1:0] cause_clr = wr_cause ? i_wdata[`SFM_RC_W-1:0] : '0;
  wire  [`SFM_EX_W-1:0] exc_clr   = wr_exc ? i_wdata[`SFM_EX_W-1:0] : '0;
  wire                  hv_clr    = i_wr && hit(i_addr, `SFM_REG_HV_STATUS) && i_wdata[0];

  // cause bits take no system reset: they must outlive the reset they name
  always_ff @(posedge i_mclk) begin
    cause_q <= (cause_q & ~cause_clr) | rst_ev;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n || state_q == ST_CHIP_RESET) begin
      exc_q      <= '0;
      mask_q     <= `SFM_EXC_MASK_RST;
      lsel_q     <= `SFM_LSEL_RST;
      inv_ecc_q  <= 1'b0;
      hv_fail_q  <= 1'b0;
      hv_done_q  <= 1'b0;
      corr_cnt_q <= 8'h00;
    end else begin
      exc_q <= (exc_q & ~exc_clr) | exc_ev;
      if (wr_mask) mask_q <= i_wdata[`SFM_EX_W-1:0];
      if (wr_lsel) lsel_q <= i_wdata[1:0];
      if (wr_cfg) inv_ecc_q <= i_wdata[`SFM_CFG_INV_ECC];
      if (nvm_wr) begin
        hv_fail_q <= !hv_ok;
        hv_done_q <= 1'b1;
      end else if (hv_clr) begin
        hv_done_q <= 1'b0;
      end
      // correction is done in the memory; only counted here
      if (ecc_corr && corr_cnt_q != 8'hff) corr_cnt_q <= corr_cnt_q + 8'h01;
    end
  end

  // ==========================================================
  // read mux and outputs
  // ==========================================================
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (i_addr)
      `SFM_REG_RESET_CAUSE:  rd_mux = 16'(cause_q);
      `SFM_REG_EXC_STATUS:   rd_mux = 16'(exc_q);
      `SFM_REG_EXC_MASK:     rd_mux = 16'(mask_q);
      `SFM_REG_LIGHT_SEL:    rd_mux = 16'(lsel_q);
      `SFM_REG_HV_STATUS:    rd_mux = {corr_cnt_q, 6'h00, hv_fail_q, hv_done_q};
      `SFM_REG_SP_LIMIT_USR: rd_mux = 16'(lim_q[0]);
      `SFM_REG_SP_LIMIT_SYS: rd_mux = 16'(lim_q[1]);
      `SFM_REG_SP_LIMIT_SSM: rd_mux = 16'(lim_q[2]);
      `SFM_REG_CONFIG:       rd_mux = 16'(inv_ecc_q);
      `SFM_REG_MODE:         rd_mux = {13'h0000, test_avail, sensors_on, test_locked_q};
      default:               rd_mux = 16'h0000;
    endcase
  end

  wire exc_pending = |(exc_q & ~mask_q);
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_rdata      <= 16'h0000;
      o_chip_reset <= 1'b0;
      o_exception  <= 1'b0;
      o_irq        <= 1'b0;
      o_sensors_on <= 1'b1;
      o_test_avail <= 1'b0;
    end else begin
      o_rdata      <= i_rd ? rd_mux : 16'h0000;
      o_chip_reset <= state_d == ST_CHIP_RESET;
      o_exception  <= |exc_ev && state_q == ST_RUN;
      o_irq        <= exc_pending;
      o_sensors_on <= sensors_on;
      o_test_avail <= test_avail;
    end
  end

endmodule

// ==== sim/security_fault_monitor_monitor.sv ====
// port assertions of the fault monitor
`timescale 1ns/1ps
module security_fault_monitor_monitor (
  input wire logic        i_mclk,           // clock
  input wire logic        i_reset_n,        // reset, low
  input wire logic        i_ext_reset_n,    // ext reset, low
  input wire logic        i_sens_voltage,   // sensor
  input wire logic        i_sens_freq,      // sensor
  input wire logic        i_sens_temp,      // sensor
  input wire logic        i_sens_light,     // sensor
  input wire logic        i_rom_parity_err, // parity
  input wire logic        i_fi_pc,          // fault
  input wire logic        i_fi_sp,          // fault
  input wire logic        i_fi_program_status_word_high,        // fault
  input wire logic        i_fi_des,         // fault
  input wire logic        i_fi_arith,       // fault
  input wire logic        i_test_fuse,      // fuse
  input wire logic [1:0]  i_cpu_mode,       // mode
  input wire logic        i_rd,             // read
  input wire logic [15:0] o_rdata,          // read data
  input wire logic        o_chip_reset,     // reset out
  input wire logic        o_exception,      // exception
  input wire logic        o_sensors_on,     // sensors on
  input wire logic        o_test_avail      // test avail
);
  logic       sens_any;
  logic       fi_any;
  logic [3:0] src_age_q;
  assign sens_any = i_sens_voltage | i_sens_freq | i_sens_temp | i_sens_light;
  assign fi_any   = i_fi_pc | i_fi_sp | i_fi_program_status_word_high | i_fi_des | i_fi_arith;
  // cycles since a reset source was seen
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      src_age_q <= 4'hf;
    end else if (sens_any | i_rom_parity_err | ~i_ext_reset_n) begin
      src_age_q <= 4'h0;
    end else if (src_age_q != 4'hf) begin
      src_age_q <= src_age_q + 4'h1;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  sequence s_sens_held; (sens_any && o_sensors_on) [*3]; endsequence
  sequence s_fi_held; (fi_any && !o_chip_reset) [*3]; endsequence
  sequence s_fuse_held; i_test_fuse [*3]; endsequence
  AST_SENS_RESET: assert property (s_sens_held |-> ##[0:6] o_chip_reset)
    else $error("sensor gave no chip reset");
  AST_PARITY_RESET: assert property (i_rom_parity_err [*3] |-> ##[0:6] o_chip_reset)
    else $error("parity gave no chip reset");
  AST_FI_EXC: assert property (s_fi_held |-> ##[0:6] (o_exception || o_chip_reset))
    else $error("fault gave no exception");
  AST_RESET_SOURCE: assert property ($rose(o_chip_reset) |-> src_age_q < 4'h8)
    else $error("chip reset without a reset source");
  AST_RESET_WINDOW: assert property ($rose(o_chip_reset) |-> o_chip_reset [*4] ##1 !o_chip_reset)
    else $error("chip reset window length");
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
    else $error("read data outside read cycle");
  AST_SENS_ON: assert property (($past(i_cpu_mode) < 2'h2) || (!o_test_avail && !$past(o_test_avail)) |-> o_sensors_on)
    else $error("sensors off outside test mode");
  AST_FUSE_LOCK: assert property (s_fuse_held |-> ##[0:4] !o_test_avail)
    else $error("test mode left available");
  AST_TEST_GONE: assert property ($fell(o_test_avail) |=> !o_test_avail [*8])
    else $error("test mode came back");
endmodule
bind security_fault_monitor security_fault_monitor_monitor u_mon (
  .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ext_reset_n(i_ext_reset_n),
  .i_sens_voltage(i_sens_voltage), .i_sens_freq(i_sens_freq), .i_sens_temp(i_sens_temp),
  .i_sens_light(i_sens_light), .i_rom_parity_err(i_rom_parity_err), .i_fi_pc(i_fi_pc),
  .i_fi_sp(i_fi_sp), .i_fi_program_status_word_high(i_fi_program_status_word_high), .i_fi_des(i_fi_des), .i_fi_arith(i_fi_arith),
  .i_test_fuse(i_test_fuse), .i_cpu_mode(i_cpu_mode), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_chip_reset(o_chip_reset), .o_exception(o_exception), .o_sensors_on(o_sensors_on),
  .o_test_avail(o_test_avail));

// ==== sim/security_fault_monitor_tb.sv ====
// self-checking bench of the fault monitor
`timescale 1ns/1ps
`include "security_fault_monitor_consts.svh"
module security_fault_monitor_tb;
  logic        i_mclk, i_reset_n, i_test_fuse, i_wr, i_rd, hv_ok, ex, cr;
  logic        o_chip_reset, o_exception, o_irq, o_sensors_on, o_test_avail;
  logic [1:0]  i_cpu_mode, i_super_mode;
  logic [3:0]  i_addr;
  logic [15:0] ev, i_sp, i_wdata, o_rdata, d, lim;
  int          mismatches, n_tests, seed, ls, inv, idx, a, n;
  security_fault_monitor dut (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ext_reset_n(~ev[15]),
    .i_sens_voltage(ev[0]), .i_sens_freq(ev[1]), .i_sens_temp(ev[2]),
    .i_sens_light(ev[3]), .i_rom_parity_err(ev[4]), .i_fi_pc(ev[5]), .i_fi_sp(ev[6]),
    .i_fi_program_status_word_high(ev[7]), .i_fi_des(ev[8]), .i_fi_arith(ev[9]), .i_nvm_light_a(ev[10]),
    .i_nvm_light_b(ev[11]), .i_ecc_err(ev[12]), .i_ecc_corr(ev[13]), .i_nvm_write(ev[14]),
    .i_hv_ok(hv_ok), .i_test_fuse(i_test_fuse), .i_cpu_mode(i_cpu_mode),
    .i_super_mode(i_super_mode), .i_sp(i_sp), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_chip_reset(o_chip_reset),
    .o_exception(o_exception), .o_irq(o_irq), .o_sensors_on(o_sensors_on),
    .o_test_avail(o_test_avail));
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [15:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, output logic [15:0] v);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  // pulse one event line 3 cycles, note reactions, wait out a reset
  task automatic hit(input int id);
    int k;
    ex = 1'b0;
    cr = 1'b0;
    for (k = 0; k < 16; k++) begin
      @(posedge i_mclk);
      ev <= (k < 3) ? 16'h1 << id : 16'h0;
      hv_ok <= !(id == 14 && k < 3);
      #1 ex = ex | o_exception;
      cr = cr | o_chip_reset;
    end
    for (k = 0; k < 20 && o_chip_reset; k++) begin
      @(posedge i_mclk);
      #1;
    end
    if (o_chip_reset) begin
      mismatches++;
      close_out;
    end
    repeat (3) @(posedge i_mclk);
  endtask
  function automatic logic [15:0] exp_stat(input int id, input int l, input int e);
    if (id >= 5 && id <= 9) return 16'h1 << (id - 4);
    if (id == 10) return {15'h0, l == `SFM_LSEL_FUNC_A};
    if (id == 11) return {15'h0, l == `SFM_LSEL_FUNC_B};
    if (id == 12 && e != 0) return 16'h1 << `SFM_EX_ECC;
    return 16'h0;
  endfunction
  function automatic logic [15:0] exp_rst(input int ad);
    if (ad == `SFM_REG_EXC_MASK) return {8'h0, `SFM_EXC_MASK_RST};
    if (ad == `SFM_REG_LIGHT_SEL) return {14'h0, `SFM_LSEL_RST};
    return 16'h0;
  endfunction
  task automatic run_case(input int id, input int l, input int e);
    logic [15:0] es;
    es = exp_stat(id, l, e);
    wr(`SFM_REG_LIGHT_SEL, l[15:0]);
    wr(`SFM_REG_CONFIG, e[15:0]);
    wr(`SFM_REG_EXC_MASK, 16'h0);
    hit(id);
    chk1(cr, id < 5);
    chk1(ex, es != 16'h0);
    rd(`SFM_REG_RESET_CAUSE, d);
    chk16(d, id < 5 ? 16'h1 << id : 16'h0);
    rd(`SFM_REG_EXC_STATUS, d);
    chk16(d, es);
    chk1(o_irq, es != 16'h0);
    rd(`SFM_REG_EXC_MASK, d);
    chk16(d, id < 5 ? 16'h00ff : 16'h0);
    wr(`SFM_REG_RESET_CAUSE, 16'h007f);
    wr(`SFM_REG_EXC_STATUS, 16'h00ff);
  endtask
  initial begin
    #10000000;
    mismatches++;
    close_out;
  end
  initial begin
    seed = 78025;
    {mismatches, n_tests} = 0;
    {i_reset_n, i_test_fuse, i_wr, i_rd, i_cpu_mode, i_super_mode} = 0;
    {ev, i_sp, i_addr, i_wdata} = 0;
    hv_ok = 1'b1;
    repeat (6) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_cpu_mode <= 2'h2;
    i_super_mode <= 2'h1;
    repeat (4) @(posedge i_mclk);
    #1 chk1(o_test_avail, 1'b1);
    chk1(o_sensors_on, 1'b0);
    @(posedge i_mclk);
    i_test_fuse <= 1'b1;
    repeat (6) @(posedge i_mclk);
    i_test_fuse <= 1'b0;
    i_cpu_mode <= 2'h0;
    repeat (6) @(posedge i_mclk);
    #1 chk1(o_test_avail, 1'b0);
    chk1(o_sensors_on, 1'b1);
    wr(`SFM_REG_MODE, 16'h0000);
    rd(`SFM_REG_MODE, d);
    chk16(d, 16'h0003);
    wr(`SFM_REG_RESET_CAUSE, 16'h007f);
    for (a = 1; a < 16; a++) begin
      rd(a[3:0], d);
      if (a != `SFM_REG_MODE) chk16(d, exp_rst(a));
    end
    for (ls = 0; ls < 4; ls++)
      for (inv = 0; inv < 2; inv++)
        for (idx = 0; idx < 13; idx++) run_case(idx, ls, inv);
    wr(`SFM_REG_EXC_MASK, 16'h0002);
    hit(5);
    #1 chk1(o_irq, 1'b0);
    wr(`SFM_REG_EXC_MASK, 16'h0000);
    rd(`SFM_REG_EXC_STATUS, d);
    chk1(o_irq, 1'b1);
    wr(`SFM_REG_EXC_STATUS, 16'h0002);
    rd(`SFM_REG_EXC_STATUS, d);
    chk1(o_irq, 1'b0);
    lim = 16'h0100 + ($random(seed) & 16'h0fff);
    wr(`SFM_REG_SP_LIMIT_USR, lim);
    wr(`SFM_REG_SP_LIMIT_SYS, 16'hf000);
    i_sp <= lim + ($random(seed) & 16'h00ff);
    hit(15);
    chk1(ex, 1'b1);
    i_sp <= lim - 16'h1;
    wr(`SFM_REG_EXC_STATUS, 16'h00ff);
    hit(15);
    chk1(ex, 1'b0);
    i_cpu_mode <= 2'h1;
    i_sp <= lim;
    hit(15);
    chk1(ex, 1'b0);
    i_sp <= 16'hf000;
    hit(15);
    chk1(ex, 1'b1);
    rd(`SFM_REG_RESET_CAUSE, d);
    chk16(d, 16'h1 << `SFM_RC_EXTERNAL);
    i_sp <= 16'h0;
    wr(`SFM_REG_EXC_STATUS, 16'h00ff);
    n = 1 + ($random(seed) & 15);
    repeat (n) begin
      @(posedge i_mclk);
      ev[13] <= 1'b1;
      @(posedge i_mclk);
      ev[13] <= 1'b0;
      @(posedge i_mclk);
    end
    hit(14);
    chk1(ex | cr, 1'b0);
    rd(`SFM_REG_HV_STATUS, d);
    chk16(d, {n[7:0], 8'h03});
    close_out;
  end
endmodule
